// ==== design/sitp_unit.sv ====
// Test pulse unit for four safe inputs with a Wishbone register slave.
// Assumes a 250 MHz REF_CLK, return inputs synchronous to it,
// and a classic single-cycle Wishbone master.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sitp_defs.svh"

module sitp_unit #(
    parameter int unsigned PULSE_CYC = `SITP_PULSE_CYC,
    parameter int unsigned CYCLE_CYC = `SITP_CYCLE_CYC
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output var logic [31:0] WB_DAT_O,
    output var logic WB_ACK_O,
    input wire logic [3:0] RET_IN,
    output var logic [3:0] TEST_OUT,
    output var logic IRQ
);

    // Number of channels served by the unit.
    localparam int NCH = 4;
    // Length of one channel slot within the test cycle.
    localparam int unsigned SLOT_CYC = CYCLE_CYC / NCH;
    // Last value of the cycle counter.
    localparam logic [`SITP_CNT_W-1:0] CYC_LAST = `SITP_CNT_W'(CYCLE_CYC - 1);

    // Bus request gathered into one carrier.
    sitp_pkg::sitp_wb_req_t req;
    // A new bus access, seen once per request.
    logic access;
    // Write and read strobes for the register file.
    logic wr_en;
    logic rd_en;

    // Sensor test enables, one per channel.
    logic [3:0] en_q;
    // Sticky status: sensor errors low nibble, open circuit high nibble.
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    // Interrupt mask of the same layout as the status.
    logic [7:0] mask_q;
    // Bits cleared by the current write.
    logic [7:0] w1c;
    // Events raised by the channels this cycle.
    logic [7:0] ev;
    // Held input levels of the channels.
    logic [3:0] level;

    // Position in the test cycle.
    logic [`SITP_CNT_W-1:0] fcnt_q;
    // Spacing generator, advanced once per test cycle.
    logic [31:0] lfsr_q;
    // Jitter offsets of the current cycle, one byte per channel.
    logic [31:0] jit_q;
    // End of the test cycle.
    logic wrap;

    // Channel results.
    sitp_pkg::sitp_chan_stat_t chs [NCH];
    // Start strobes, one per channel.
    logic [3:0] start;

    // Collects the bus inputs.
    assign req.adr = WB_ADR_I;
    assign req.we = WB_WE_I;
    assign req.sel = WB_SEL_I;
    assign req.dat = WB_DAT_I;

    // One access per request: nothing is taken while ack is high.
    assign access = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_en = access && req.we;
    assign rd_en = access && !req.we;

    // Test cycle end.
    assign wrap = (fcnt_q == CYC_LAST);

    // Test cycle counter, free running from reset.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fcnt_q <= '0;
        end else if (wrap) begin
            fcnt_q <= '0;
        end else begin
            fcnt_q <= fcnt_q + 1'b1;
        end
    end

    // Spacing generator steps once per test cycle.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lfsr_q <= `SITP_LFSR_SEED;
        end else if (wrap) begin
            if (lfsr_q[0]) begin
                lfsr_q <= (lfsr_q >> 1) ^ `SITP_LFSR_TAPS;
            end else begin
                lfsr_q <= lfsr_q >> 1;
            end
        end
    end

    // Jitter offsets are frozen for a whole cycle so each slot fires once.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            jit_q <= '0;
        end else if (wrap) begin
            jit_q <= lfsr_q;
        end
    end

    // Per-channel scheduling and checking.
    for (genvar k = 0; k < NCH; k++) begin : g_ch
        // Slot start of this channel within the test cycle.
        localparam logic [`SITP_CNT_W-1:0] BASE = `SITP_CNT_W'(k * SLOT_CYC);
        // Jitter of this channel, in clock cycles.
        logic [`SITP_CNT_W-1:0] jit;

        assign jit = `SITP_CNT_W'({jit_q[8*k +: 8], {`SITP_JIT_SHIFT{1'b0}}});

        // One start per test cycle, at a varying point in its own slot.
        assign start[k] = (fcnt_q == BASE + jit);

        sitp_chan #(
            .PULSE_CYC(PULSE_CYC),
            .WIN_CYC(`SITP_WIN_CYC)
        ) u_chan (
            .clk(REF_CLK),
            .nrst(NRST),
            .enable(en_q[k]),
            .start(start[k]),
            .ret_in(RET_IN[k]),
            .test_out(TEST_OUT[k]),
            .stat(chs[k])
        );

        // Gathers the channel results into the status layout.
        assign ev[k] = chs[k].sens_ev;
        assign ev[k+4] = chs[k].open_ev;
        assign level[k] = chs[k].level;
    end

    // Sensor test enable register.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            en_q <= `SITP_CTRL_RST;
        end else if (wr_en && req.sel[0] && req.adr == `SITP_ADR_CTRL) begin
            en_q <= req.dat[3:0];
        end
    end

    // Interrupt mask register.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_q <= `SITP_MASK_RST;
        end else if (wr_en && req.sel[0] && req.adr == `SITP_ADR_MASK) begin
            mask_q <= req.dat[7:0];
        end
    end

    // Writing a one clears a status bit; a new event wins over the clear.
    always_comb begin
        w1c = 8'h00;
        if (wr_en && req.sel[0] && req.adr == `SITP_ADR_STAT) begin
            w1c = req.dat[7:0];
        end
        stat_d = (stat_q & ~w1c) | ev;
    end

    // Sticky status register.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            stat_q <= 8'h00;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Interrupt is high while an unmasked status bit is set.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat_d & mask_q);
        end
    end

    // Acknowledge one cycle after the request, for one cycle.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= access;
        end
    end

    // Read data, registered with the acknowledge.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (rd_en) begin
            case (req.adr)
                // Enables as written.
                `SITP_ADR_CTRL: begin
                    WB_DAT_O <= {28'h0000000, en_q};
                end
                // Held input levels, contact polarity left to the controller.
                `SITP_ADR_LEVEL: begin
                    WB_DAT_O <= {28'h0000000, level};
                end
                // Sticky diagnostics.
                `SITP_ADR_STAT: begin
                    WB_DAT_O <= {24'h000000, stat_q};
                end
                // Interrupt mask.
                `SITP_ADR_MASK: begin
                    WB_DAT_O <= {24'h000000, mask_q};
                end
                // Unmapped addresses read as zero.
                default: begin
                    WB_DAT_O <= 32'h0000_0000;
                end
            endcase
        end else begin
            WB_DAT_O <= 32'h0000_0000;
        end
    end

endmodule : sitp_unit
`default_nettype wire

// ==== design/sitp_defs.svh ====
// Constants of the safe input test pulse unit: timing, register map, resets.
// Assumes a 250 MHz reference clock and a 32-bit classic Wishbone register bus.
`ifndef SITP_DEFS_SVH
`define SITP_DEFS_SVH

// Clock rate in MHz.
`define SITP_CLK_MHZ 250
// Low time of one test pulse in microseconds, and in clock cycles.
`define SITP_PULSE_US 350
`define SITP_PULSE_CYC (`SITP_PULSE_US * `SITP_CLK_MHZ)
// Test cycle covering all channels in microseconds, and in clock cycles.
`define SITP_CYCLE_US 4000
`define SITP_CYCLE_CYC (`SITP_CYCLE_US * `SITP_CLK_MHZ)
// Time allowed for the return input to rise again after a pulse.
`define SITP_WIN_US 10
`define SITP_WIN_CYC (`SITP_WIN_US * `SITP_CLK_MHZ)
// Width of the cycle counters.
`define SITP_CNT_W 20
// Jitter byte is shifted left by this many bits before use.
`define SITP_JIT_SHIFT 4

// Register byte addresses.
`define SITP_ADR_CTRL 8'h00
`define SITP_ADR_LEVEL 8'h04
`define SITP_ADR_STAT 8'h08
`define SITP_ADR_MASK 8'h0c

// Reset values.
`define SITP_CTRL_RST 4'h0
`define SITP_MASK_RST 8'h00
`define SITP_LFSR_SEED 32'h1d2c3b4a
// Feedback taps of the spacing generator.
`define SITP_LFSR_TAPS 32'h80200003

`endif

// ==== design/sitp_pkg.sv ====
// Types shared by the test pulse unit and its channel module.
// Assumes sitp_defs.svh supplies all numeric constants.
package sitp_pkg;

    // Channel sequencer states, one-hot.
    typedef enum logic [2:0] {
        SITP_IDLE = 3'b001,
        SITP_LOW = 3'b010,
        SITP_RECOV = 3'b100
    } sitp_state_t;

    // Per-channel result: held level and one-cycle error events.
    typedef struct packed {
        logic level;
        logic sens_ev;
        logic open_ev;
    } sitp_chan_stat_t;

    // One Wishbone request as seen by the slave.
    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } sitp_wb_req_t;

endpackage : sitp_pkg

// ==== design/sitp_chan.sv ====
// One test channel: drives the plus terminal, checks the return input.
// Assumes start is a one-cycle pulse and ret_in is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "sitp_defs.svh"

module sitp_chan #(
    parameter int unsigned PULSE_CYC = `SITP_PULSE_CYC,
    parameter int unsigned WIN_CYC = `SITP_WIN_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic start,
    input wire logic ret_in,
    output var logic test_out,
    output var sitp_pkg::sitp_chan_stat_t stat
);

    localparam logic [`SITP_CNT_W-1:0] LOW_LAST = `SITP_CNT_W'(PULSE_CYC - 1);
    localparam logic [`SITP_CNT_W-1:0] WIN_LAST = `SITP_CNT_W'(WIN_CYC - 1);

    sitp_pkg::sitp_state_t state_q; // Sequencer state.
    logic [`SITP_CNT_W-1:0] cnt_q; // Cycles spent in the current phase.
    logic was_high_q; // Return level seen just before the pulse.
    logic low_end; // Last cycle of the low phase.
    logic rec_to; // Return failed to rise in time.
    logic level_q; // Reported input level.
    logic sens_q; // Sensor error event, one cycle.
    logic open_q; // Open circuit error event, one cycle.

    // The result carrier is driven from one place only.
    assign stat = '{level: level_q, sens_ev: sens_q, open_ev: open_q};

    // Phase end conditions.
    assign low_end = (state_q == sitp_pkg::SITP_LOW) && (cnt_q == LOW_LAST);
    assign rec_to = (state_q == sitp_pkg::SITP_RECOV) && (cnt_q == WIN_LAST) && !ret_in;

    // Sequencer: idle, low phase, recovery window.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= sitp_pkg::SITP_IDLE;
            cnt_q <= '0;
        end else if (!enable) begin
            // Disabling aborts any pulse at once.
            state_q <= sitp_pkg::SITP_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                sitp_pkg::SITP_IDLE: begin
                    if (start) begin
                        state_q <= sitp_pkg::SITP_LOW;
                        cnt_q <= '0;
                    end
                end
                sitp_pkg::SITP_LOW: begin
                    if (low_end) begin
                        state_q <= sitp_pkg::SITP_RECOV;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                sitp_pkg::SITP_RECOV: begin
                    // Leave as soon as the return is high again.
                    if (ret_in || rec_to) begin
                        state_q <= sitp_pkg::SITP_IDLE;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= sitp_pkg::SITP_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // Test output is low only in the low phase of an enabled channel.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_out <= 1'b1;
        end else if (!enable) begin
            test_out <= 1'b1;
        end else if (state_q == sitp_pkg::SITP_IDLE) begin
            test_out <= !start;
        end else begin
            test_out <= !(state_q == sitp_pkg::SITP_LOW) || low_end;
        end
    end

    // Remembers whether the contact was closed when the pulse began.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            was_high_q <= 1'b0;
        end else if (state_q == sitp_pkg::SITP_IDLE && start) begin
            was_high_q <= ret_in;
        end
    end

    // Reported level follows the return outside pulses and holds during them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            level_q <= 1'b0;
        end else if (!enable || state_q == sitp_pkg::SITP_IDLE) begin
            level_q <= ret_in;
        end
    end

    // Diagnostic events, one cycle each.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sens_q <= 1'b0;
            open_q <= 1'b0;
        end else begin
            // A closed contact must carry the low phase back.
            sens_q <= enable && low_end && ret_in && was_high_q;
            // Return that stays low after the pulse is a lost circuit.
            open_q <= enable && rec_to && was_high_q;
        end
    end

endmodule : sitp_chan
`default_nettype wire

// ==== test/sitp_unit_properties.sv ====
// Checker for the test pulse unit; it sees only the unit's ports.
// Assumes writes need byte lane 0 and the unit is bound by parameters.
`timescale 1ns/1ps
`default_nettype none
module sitp_unit_chk #(
    parameter int unsigned PULSE_CYC = 20,
    parameter int unsigned CYCLE_CYC = 28672
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [3:0] RET_IN,
    input wire logic [3:0] TEST_OUT,
    input wire logic IRQ
);
    // Longest wait between pulse starts: one cycle plus 4200, above the largest jitter of 4080.
    localparam int GAP_MAX = CYCLE_CYC + 4200;
    logic take; // A request the slave takes at this edge.
    logic [3:0] ctrl_q; // Shadow of the enable register.
    logic [7:0] mask_q; // Shadow of the mask register.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    sequence take_s; take; endsequence
    sequence ack_s; WB_ACK_O ##1 !WB_ACK_O; endsequence
    // The shadows follow the writes that the slave takes.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= 4'h0;
            mask_q <= 8'h00;
        end else if (take && WB_WE_I && WB_SEL_I[0]) begin
            if (WB_ADR_I == 8'h00) ctrl_q <= WB_DAT_I[3:0];
            if (WB_ADR_I == 8'h0c) mask_q <= WB_DAT_I[7:0];
        end
    end
    ack_next_a: assert property (take_s |=> ack_s)
        else $error("bus request not answered in one cycle");
    dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside the ack cycle");
    dat_top_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data above byte lane 0");
    idle_high_a: assert property (&(TEST_OUT | $past(ctrl_q)))
        else $error("disabled channel left its high level");
    irq_mask_a: assert property ($past(mask_q) == 8'h00 |-> !IRQ)
        else $error("interrupt with every source masked");
    for (genvar k = 0; k < 4; k++) begin : g_ch
        logic [19:0] low_q; // Low cycles of the current pulse.
        logic [19:0] gap_q; // Cycles since the last pulse began.
        logic rs_q; // Return level when the pulse began.
        // The counters run from the test output and the enable shadow.
        always_ff @(posedge REF_CLK or negedge NRST) begin
            if (!NRST) begin
                low_q <= 20'h0;
                gap_q <= 20'h0;
                rs_q <= 1'b0;
            end else begin
                low_q <= TEST_OUT[k] ? 20'h0 : low_q + 20'h1;
                gap_q <= (!ctrl_q[k] || $fell(TEST_OUT[k])) ? 20'h0 : gap_q + 20'h1;
                if ($fell(TEST_OUT[k])) rs_q <= RET_IN[k];
            end
        end
        width_a: assert property ($rose(TEST_OUT[k]) && ctrl_q[k] && $past(ctrl_q[k])
            |-> low_q == PULSE_CYC) else $error("pulse low time wrong");
        rate_a: assert property (gap_q <= GAP_MAX)
            else $error("test pulse overdue");
        sense_a: assert property (!TEST_OUT[k] && low_q == PULSE_CYC - 1 && RET_IN[k]
            && rs_q && ctrl_q[k] && mask_q[k] |-> ##[1:4] IRQ)
            else $error("return stuck high not flagged");
    end
endmodule : sitp_unit_chk
bind sitp_unit sitp_unit_chk #(.PULSE_CYC(PULSE_CYC), .CYCLE_CYC(CYCLE_CYC)) u_chk (
    .REF_CLK(REF_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RET_IN(RET_IN), .TEST_OUT(TEST_OUT),
    .IRQ(IRQ));
`default_nettype wire

// ==== test/sitp_contact_model.sv ====
// Model of the contacts wired between test outputs and return inputs.
// Assumes one clock; mode 0 closed, 1 shorted high, 2 breaks open, 3 open.
`timescale 1ns/1ps
`default_nettype none
module sitp_contact_model (
    input wire logic clk,
    input wire logic [3:0] test_out,
    input wire logic [7:0] mode,
    input wire logic slow,
    output var logic [3:0] ret
);
    logic [3:0] d1_q; // Test outputs one cycle late.
    logic [3:0] d2_q; // Two cycles late.
    logic [3:0] d3_q; // Three cycles late, for a slow sensor.
    logic [3:0] brk_q; // Contacts that broke open after a low phase.
    // The wiring delays the test output; a broken contact stays open.
    always_ff @(posedge clk) begin
        d1_q <= test_out;
        d2_q <= d1_q;
        d3_q <= d2_q;
        for (int k = 0; k < 4; k++) begin
            brk_q[k] <= (mode[2*k+:2] == 2'h2) && (brk_q[k] || !d1_q[k]);
        end
    end
    // Each contact passes, pins or cuts the returned level.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            case (mode[2*k+:2])
                2'h0: ret[k] = slow ? d3_q[k] : d1_q[k];
                2'h1: ret[k] = 1'b1;
                2'h2: ret[k] = d1_q[k] && !brk_q[k];
                default: ret[k] = 1'b0;
            endcase
        end
    end
endmodule : sitp_contact_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the test pulse unit with its contact model.
// Assumes the unit's package, defines and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned PC = 20; // Short pulse for simulation.
    localparam int unsigned CC = 28672; // Short test cycle; each slot still fits.
    logic REF_CLK = 1'b0;
    logic NRST, cyc, stb, we, slow;
    logic [3:0] sel = 4'hf; // Byte enables of the next request.
    logic [7:0] adr, mode;
    logic [31:0] wdat, rd;
    logic [3:0] lv, prev;
    wire logic [31:0] rdat;
    wire logic ack, irq;
    wire logic [3:0] ret, tout;
    int errors = 0;
    int checked = 0;
    int seed = 32'h7771b31c;
    int now, t;
    int lowc[4], nfall[4], ft[2];
    bit wchk = 1'b0; // Pulse widths are compared only while set.
    sitp_unit #(.PULSE_CYC(PC), .CYCLE_CYC(CC)) uut (
        .REF_CLK(REF_CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .RET_IN(ret), .TEST_OUT(tout), .IRQ(irq));
    sitp_contact_model u_wire (.clk(REF_CLK), .test_out(tout), .mode(mode), .slow(slow),
        .ret(ret));
    always #2 REF_CLK = ~REF_CLK;
    task automatic test_done();
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge REF_CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            errors++;
            test_done();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("register %h", a), rd, e);
    endtask : rdchk
    // Counts pulses and measures each low phase at the test outputs.
    always @(posedge REF_CLK) begin
        now++;
        for (int k = 0; k < 4; k++) begin
            if (prev[k] === 1'b1 && tout[k] === 1'b0) begin
                nfall[k]++;
                if (k == 0) ft = '{ft[1], now};
            end
            if (prev[k] === 1'b0 && tout[k] === 1'b1 && wchk) chk("low time", lowc[k], PC);
            lowc[k] = (tout[k] === 1'b0) ? lowc[k] + 1 : 0;
        end
        prev = tout;
    end
    // Cuts a hang short; like a controller watchdog, silence past the limit is an error.
    initial begin
        repeat (100000) @(posedge REF_CLK);
        errors++;
        test_done();
    end
    initial begin
        NRST = 1'b0;
        {cyc, stb, we, slow, adr, mode, wdat} = '0;
        repeat (12) @(posedge REF_CLK);
        NRST <= 1'b1;
        @(posedge REF_CLK);
        chk("reset test outputs", tout, 32'hf);
        bus(1'b1, 8'h10, $random(seed));
        bus(1'b1, 8'h04, 32'h0);
        for (int a = 0; a < 5; a++) rdchk(8'(4 * a), (a == 1) ? 32'hf : 32'h0);
        // A write without byte lane 0 must leave the enables alone.
        sel <= 4'he;
        bus(1'b1, 8'h00, 32'hf);
        sel <= 4'hf;
        rdchk(8'h00, 32'h0);
        // Random contact levels must show up as the held input level.
        for (int i = 0; i < 4; i++) begin
            lv = 4'($random(seed));
            slow <= 1'($random(seed));
            for (int k = 0; k < 4; k++) mode[2*k+:2] <= lv[k] ? 2'h0 : 2'h3;
            repeat (8) @(posedge REF_CLK);
            rdchk(8'h04, {28'h0, lv});
        end
        // Channel 1 shorted high, channel 2 breaks open, channel 3 disabled.
        mode <= 8'h24;
        slow <= 1'b1;
        bus(1'b1, 8'h0c, 32'hff);
        bus(1'b1, 8'h00, 32'h7);
        rdchk(8'h00, 32'h7);
        wchk = 1'b1;
        for (int n = 0; nfall[0] < 2; n++) begin
            @(negedge REF_CLK);
            if (n > 3 * CC) begin
                errors++;
                test_done();
            end
        end
        chk("idle channel pulses", nfall[3], 0);
        chk("period bound", (ft[1] - ft[0]) inside {[CC - 4096 : CC + 4096]}, 1);
        chk("period varies", (ft[1] - ft[0]) != CC, 1);
        rdchk(8'h08, 32'h42);
        chk("irq raised", irq, 1);
        bus(1'b1, 8'h0c, 32'h0);
        repeat (2) @(posedge REF_CLK);
        chk("irq masked", irq, 0);
        bus(1'b1, 8'h0c, 32'h40);
        repeat (2) @(posedge REF_CLK);
        chk("irq open circuit", irq, 1);
        // Disabling channel 1 in mid-pulse returns its output high.
        wchk = 1'b0;
        t = nfall[1];
        for (int n = 0; nfall[1] == t; n++) begin
            @(negedge REF_CLK);
            if (n > CC) begin
                errors++;
                test_done();
            end
        end
        bus(1'b1, 8'h00, 32'h5);
        repeat (2) @(posedge REF_CLK);
        chk("output after disable", tout[1], 1);
        mode <= 8'h00;
        bus(1'b1, 8'h08, 32'h2);
        rdchk(8'h08, 32'h40);
        bus(1'b1, 8'h08, 32'h40);
        rdchk(8'h08, 32'h0);
        @(posedge REF_CLK);
        chk("irq cleared", irq, 0);
        test_done();
    end
endmodule : testbench
`default_nettype wire
